// >>> rtl/pfre_seq.sv
/*
 program flash row erase sequencer: region, row address, erase select,
 program enable and unlock in; start bit, stall, done flag and irq out.
 assumes the unlock pulse comes from the core on clk; protect is a
 combinational lookup on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pfre_seq
    import pfre_pkg::*;
#(
    parameter int ERASE_CYCLES = PFRE_ERASE_CYC,
    parameter int ROW_WORDS = PFRE_ROW_WORDS,
    parameter int AW = PFRE_ADDR_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control bits
    input wire logic region_select,
    input wire logic [7:0] row_address_high,
    input wire logic [7:0] row_address_low,
    input wire logic row_erase_sel,
    input wire logic program_enable,
    input wire logic unlock_done,
    input wire logic memory_op_irq_enable,
    input wire logic done_flag_clear,
    input wire logic row_protected,
    // status
    output logic op_start,
    output logic cpu_stall,
    output logic memory_op_done_flag,
    output logic memory_op_irq,
    output logic erase_row_pulse,
    output logic [AW-1:0] erase_row_addr,
    output logic erase_region
);
    localparam int OFS_W = $clog2(ROW_WORDS);
    pfre_mem_if #(.AW(AW)) mif ();
    pfre_state_e state_q;
    pfre_state_e state_d;
    logic start_q;
    logic stall_q;
    logic flag_q;
    logic irq_q;
    logic pulse_q;
    logic region_q;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_in;
    logic [AW-1:0] row_base;
    logic req;
    logic go;
    logic prot_hit;
    logic finish;
    logic flag_d;
    logic start_d;
    logic stall_d;
    logic irq_d;
    logic pulse_d;
    logic region_d;
    logic [AW-1:0] addr_d;

    pfre_row_timer #(.CYCLES(ERASE_CYCLES)) u_timer
    (
        .clk(clk),
        .rst(rst),
        .mif(mif)
    );

    assign addr_in = AW'({row_address_high, row_address_low});
    assign row_base = {addr_in[AW-1:OFS_W], {OFS_W{1'b0}}};
    assign req = row_erase_sel & program_enable;
    assign go = (state_q == PFRE_IDLE) & req & unlock_done;
    assign prot_hit = (state_q == PFRE_CHECK) & row_protected;
    assign finish = (state_q == PFRE_ERASE) & ~mif.busy & ~pulse_q;
    assign flag_d = finish | (flag_q & ~done_flag_clear);
    assign start_d = go | (start_q & ~prot_hit & ~finish);
    assign pulse_d = (state_q == PFRE_CHECK) & ~row_protected;
    assign stall_d = (state_d == PFRE_ERASE);
    assign irq_d = flag_d & memory_op_irq_enable;
    assign addr_d = go ? row_base : addr_q;
    assign region_d = go ? region_select : region_q;
    assign mif.erase_row = pulse_q;
    assign mif.region = region_q;
    assign mif.row_addr = addr_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PFRE_IDLE: if (go) state_d = PFRE_CHECK;
            PFRE_CHECK: state_d = row_protected ? PFRE_IDLE : PFRE_ERASE;
            PFRE_ERASE: if (finish) state_d = PFRE_DONE;
            PFRE_DONE: state_d = PFRE_IDLE;
            default: state_d = PFRE_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= PFRE_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // start bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= start_d;
        end
    end

    // cpu stall
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stall_q <= 1'b0;
        end
        else
        begin
            stall_q <= stall_d;
        end
    end

    // sticky done flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    // gated irq
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    // row erase pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_q <= 1'b0;
        end
        else
        begin
            pulse_q <= pulse_d;
        end
    end

    // captured region
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            region_q <= 1'b0;
        end
        else
        begin
            region_q <= region_d;
        end
    end

    // captured row base
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            addr_q <= '0;
        end
        else
        begin
            addr_q <= addr_d;
        end
    end

    // program enable and write latches are never driven here
    assign op_start = start_q;
    assign cpu_stall = stall_q;
    assign memory_op_done_flag = flag_q;
    assign memory_op_irq = irq_q;
    assign erase_row_pulse = pulse_q;
    assign erase_row_addr = addr_q;
    assign erase_region = region_q;
endmodule // pfre_seq
`default_nettype wire

// >>> rtl/pfre_pkg.sv
/*
 package for the program flash row erase sequencer: widths, timing, states.
 assumes a single 20 MHz system clock.
*/
package pfre_pkg;
    localparam int PFRE_CLK_HZ = 20_000_000;
    localparam int PFRE_ERASE_US = 2_000;
    localparam int PFRE_ERASE_CYC = (PFRE_ERASE_US * (PFRE_CLK_HZ / 1_000_000));
    localparam int PFRE_ROW_WORDS = 32;
    localparam int PFRE_ADDR_W = 15;
    localparam logic [7:0] PFRE_RST_ADDR = 8'h00;
    typedef enum logic [3:0]
    {
        PFRE_IDLE = 4'b0001,
        PFRE_CHECK = 4'b0010,
        PFRE_ERASE = 4'b0100,
        PFRE_DONE = 4'b1000
    } pfre_state_e;
endpackage

// >>> rtl/pfre_mem_if.sv
/*
 interface between the erase sequencer and the flash array model.
 assumes both ends on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface pfre_mem_if #(parameter int AW = 15);
    logic erase_row;
    logic region;
    logic [AW-1:0] row_addr;
    logic busy;
    modport seq (output erase_row, output region, output row_addr, input busy);
    modport mem (input erase_row, input region, input row_addr, output busy);
endinterface
`default_nettype wire

// >>> rtl/pfre_row_timer.sv
/*
 row erase timer: counts the erase duration for one row.
 assumes start is a one-cycle pulse on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pfre_row_timer
    import pfre_pkg::*;
#(
    parameter int CYCLES = PFRE_ERASE_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // array side
    pfre_mem_if.mem mif
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic busy_q;
    logic busy_d;
    assign busy_d = mif.erase_row ? 1'b1 : (cnt_q == 32'h0000_0001) ? 1'b0 : busy_q;
    assign cnt_d = mif.erase_row ? 32'(CYCLES) : (cnt_q != 32'h0000_0000) ? cnt_q - 32'h0000_0001 : cnt_q;
    assign mif.busy = busy_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 32'h0000_0000;
            busy_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end
endmodule // pfre_row_timer
`default_nettype wire

// >>> testbench/pfre_seq_checker.sv
/*
 port assertions for pfre_seq.
 assumes binding to every pfre_seq.
*/
`timescale 1ns/10ps
`default_nettype none
module pfre_seq_checker
    import pfre_pkg::*;
#(
    parameter int AW = PFRE_ADDR_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // inputs
    input wire logic memory_op_irq_enable,
    input wire logic row_protected,
    // status
    input wire logic op_start,
    input wire logic cpu_stall,
    input wire logic memory_op_done_flag,
    input wire logic memory_op_irq,
    input wire logic erase_row_pulse,
    input wire logic [AW-1:0] erase_row_addr
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_protect_rejects:
        assert property ($rose(op_start) && row_protected |=> !op_start && !erase_row_pulse && !cpu_stall)
        else $error("protected row not rejected");
    a_erase_begins:
        assert property ($rose(op_start) && !row_protected |=> erase_row_pulse && cpu_stall && op_start)
        else $error("erase did not begin");
    a_pulse_single:
        assert property (erase_row_pulse |=> !erase_row_pulse && cpu_stall)
        else $error("erase pulse too long");
    a_stall_ends_done:
        assert property ($fell(cpu_stall) |-> memory_op_done_flag && !op_start)
        else $error("stall ended without done");
    a_irq_follows:
        assert property ($rose(memory_op_done_flag) && $past(memory_op_irq_enable) |-> memory_op_irq)
        else $error("irq missing");
    a_irq_gated:
        assert property (memory_op_irq |-> memory_op_done_flag && $past(memory_op_irq_enable))
        else $error("irq without flag or enable");
    a_addr_holds:
        assert property (cpu_stall && $past(cpu_stall) |-> $stable(erase_row_addr))
        else $error("row address moved");
endmodule // pfre_seq_checker
bind pfre_seq pfre_seq_checker #(.AW(AW)) pfre_seq_checker_inst (.clk, .rst, .memory_op_irq_enable,
    .row_protected, .op_start, .cpu_stall, .memory_op_done_flag, .memory_op_irq, .erase_row_pulse, .erase_row_addr);
`default_nettype wire

// >>> testbench/tb.sv
/*
 bench for pfre_seq: erase, refusal and protect cases.
 assumes ERASE_CYCLES of 10.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, rst, rs, rsel, pe, ul, ie, clr, prot, st, stl, flg, irq, pul, rgn;
    logic [7:0] ah, al;
    logic [14:0] ra;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    pfre_seq #(.ERASE_CYCLES(10)) pfre_seq_inst (.clk(clk), .rst(rst), .region_select(rs),
        .row_address_high(ah), .row_address_low(al), .row_erase_sel(rsel), .program_enable(pe),
        .unlock_done(ul), .memory_op_irq_enable(ie), .done_flag_clear(clr), .row_protected(prot),
        .op_start(st), .cpu_stall(stl), .memory_op_done_flag(flg), .memory_op_irq(irq),
        .erase_row_pulse(pul), .erase_row_addr(ra), .erase_region(rgn));
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic go(input logic r, input logic [15:0] a, input logic e, input logic p, input logic en);
        @(posedge clk);
        {rs, ah, al, ie, prot, pe, rsel, ul} <= {r, a, e, p, en, 2'b11};
        @(posedge clk);
        ul <= 1'b0;
    endtask
    task automatic t_erase(input logic r, input logic [15:0] a, input logic e);
        go(r, a, e, 1'b0, 1'b1);
        for (n = 0; n < 8 && pul !== 1'b1; n++)
            @(negedge clk);
        chk({pul, stl, rgn, ra}, {2'b11, r, a[14:5], 5'h00});
        for (n = 0; n < 40 && flg !== 1'b1; n++)
            @(negedge clk);
        chk({15'h0, flg, st, stl}, 18'h4);
        @(negedge clk);
        chk({17'h0, irq}, {17'h0, e});
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic t_block(input logic [15:0] a, input logic p);
        go(1'b0, a, 1'b0, p, p);
        repeat (5) @(negedge clk);
        chk({15'h0, st, stl, flg}, 18'h0);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #100000;
        miscompares++;
        end_of_test;
    end
    initial
    begin
        {rst, rs, rsel, pe, ul, ie, clr, prot, ah, al} = {1'b1, 23'h0};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_block(16'h0020, 1'b0);
        t_erase(1'b0, 16'hffff, 1'b0);
        t_erase(1'b1, 16'h0123, 1'b1);
        t_block(16'h0040, 1'b1);
        end_of_test;
    end
endmodule // tb
`default_nettype wire
